// >>> rtl/tstl_defs.vh
/*
  Constants of the transmit start, threshold and loopback control block.
  Assumes it is included by its bare name from the design files under rtl/.
*/
`ifndef TSTL_DEFS_VH
`define TSTL_DEFS_VH

// ----------------------------------------------------------------------
// Register word offsets (byte addresses).
// ----------------------------------------------------------------------
`define TSTL_OFS_OPMODE   8'h00
`define TSTL_OFS_STATUS   8'h04
`define TSTL_OFS_MASK     8'h08
`define TSTL_OFS_POLL     8'h0c
`define TSTL_OFS_STATE    8'h10

// ----------------------------------------------------------------------
// Operation mode register fields.
// ----------------------------------------------------------------------
`define TSTL_BIT_ONE25    25
`define TSTL_BIT_SPDMODE  22
`define TSTL_BIT_SFWD     21
`define TSTL_BIT_RSV20    20
`define TSTL_BIT_RSV19    19
`define TSTL_BIT_EXTMII   18
`define TSTL_BIT_RETRY    17
`define TSTL_BIT_ONEPKT   16
`define TSTL_BIT_THR_HI   15
`define TSTL_BIT_THR_LO   14
`define TSTL_BIT_RUN      13
`define TSTL_BIT_FCOL     12
`define TSTL_BIT_LB_HI    11
`define TSTL_BIT_LB_LO    10
`define TSTL_OPMODE_RST   32'h0244_0000
`define TSTL_OPMODE_WMASK 32'h007f_fc00

// ----------------------------------------------------------------------
// Status and mask bit positions.
// ----------------------------------------------------------------------
`define TSTL_NEV          4
`define TSTL_EV_DONE      0
`define TSTL_EV_STOPPED   1
`define TSTL_EV_BUFUNAV   2
`define TSTL_EV_UNDERRUN  3

// ----------------------------------------------------------------------
// Thresholds in bytes.
// ----------------------------------------------------------------------
`define TSTL_THR_64       12'd64
`define TSTL_THR_128      12'd128
`define TSTL_THR_192      12'd192
`define TSTL_THR_256      12'd256
`define TSTL_THR_512      12'd512
`define TSTL_THR_1024     12'd1024

// ----------------------------------------------------------------------
// Loopback codes.
// ----------------------------------------------------------------------
`define TSTL_LB_NORMAL    2'b00
`define TSTL_LB_INTERNAL  2'b01

`endif

// >>> rtl/tstl_sticky.v
/*
  One sticky event flag with write-one-to-clear and a mask gate.
  Assumes a single clock, an active-high asynchronous reset and a clock enable.
*/
`timescale 1ns/1ps

module tstl_sticky (
  input  wire clk_sys,
  input  wire reset,
  input  wire clk_en,
  input  wire set_ev,
  input  wire clr_w1c,
  input  wire mask_en,
  output reg  flag_q,
  output wire pend
);

  // ----------------------------------------------------------------------
  // Flag storage.
  // ----------------------------------------------------------------------
  // The set wins over a clear in the same cycle so that no event is lost.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (set_ev) begin
        flag_q <= 1'b1;
      end else if (clr_w1c) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Masked contribution to the interrupt line.
  assign pend = flag_q & mask_en;

endmodule // tstl_sticky

// >>> rtl/tstl_ctrl.v
/*
  Transmit start, threshold and loopback control of a fast Ethernet controller.
  Holds the operation mode register, the transmit process state machine, the
  start decision (store-and-forward or FIFO threshold), underrun retry, one
  packet mode, force collision, loopback and external MII selection.
  Assumes a descriptor fetch engine, a DMA that fills the transmit FIFO and
  reports its fill level, and a MAC that reports done and underrun, all
  synchronous to clk_sys.
*/
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tstl_defs.vh"

module tstl_ctrl (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clk_en,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire        irq,
  output reg         desc_fetch_req,
  input  wire        desc_fetch_ack,
  input  wire        desc_dev_owned,
  output wire        dma_load_allow,
  input  wire        dma_frame_loaded,
  input  wire [11:0] fifo_level,
  output reg         mac_tx_start,
  output reg         mac_tx_retry,
  input  wire        mac_tx_done,
  input  wire        mac_underrun,
  input  wire        auto_poll_expire,
  output reg  [1:0]  loopback_select,
  output reg         loopback_route,
  output reg         collision_detect_en,
  output reg         force_collision,
  output reg         ext_mii_select,
  output reg         int_phy_enable
);

  // ----------------------------------------------------------------------
  // Transmit process states.
  // ----------------------------------------------------------------------
  localparam [2:0] ST_STOP  = 3'd0;
  localparam [2:0] ST_FETCH = 3'd1;
  localparam [2:0] ST_SUSP  = 3'd2;
  localparam [2:0] ST_MOVE  = 3'd3;
  localparam [2:0] ST_SEND  = 3'd4;

  reg  [31:0]            opmode_q;
  reg  [`TSTL_NEV-1:0]   mask_q;
  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg                    loaded_q;
  reg                    loaded_d;
  reg  [11:0]            thr;
  reg                    start_ok;
  reg  [`TSTL_NEV-1:0]   ev_set;
  reg                    fetch_d;
  reg                    start_d;
  reg                    retry_d;
  wire [`TSTL_NEV-1:0]   stat_q;
  wire [`TSTL_NEV-1:0]   pend;
  wire                   wr_opmode;
  wire                   wr_status;
  wire                   poll_cmd;
  wire                   run_cmd;
  wire                   sfwd_mode;
  wire                   spd_mode;
  wire [1:0]             thr_code;
  wire [1:0]             lb_code;

  // ----------------------------------------------------------------------
  // Register decode and mode fields.
  // ----------------------------------------------------------------------
  assign wr_opmode = reg_wr & (reg_addr == `TSTL_OFS_OPMODE);
  assign wr_status = reg_wr & (reg_addr == `TSTL_OFS_STATUS);
  assign poll_cmd  = reg_wr & (reg_addr == `TSTL_OFS_POLL);
  assign run_cmd   = opmode_q[`TSTL_BIT_RUN];
  assign sfwd_mode = opmode_q[`TSTL_BIT_SFWD];
  assign spd_mode  = opmode_q[`TSTL_BIT_SPDMODE];
  assign thr_code  = {opmode_q[`TSTL_BIT_THR_HI], opmode_q[`TSTL_BIT_THR_LO]};
  assign lb_code   = {opmode_q[`TSTL_BIT_LB_HI], opmode_q[`TSTL_BIT_LB_LO]};

  // Operation mode register; reset leaves speed mode and external MII set.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      opmode_q <= `TSTL_OPMODE_RST;
    end else if (clk_en && wr_opmode) begin
      opmode_q <= (reg_wdata & `TSTL_OPMODE_WMASK) | `TSTL_OPMODE_RST & ~`TSTL_OPMODE_WMASK;
    end
  end

  // Mask register, same layout as the status register.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mask_q <= {`TSTL_NEV{1'b0}};
    end else if (clk_en && reg_wr && reg_addr == `TSTL_OFS_MASK) begin
      mask_q <= reg_wdata[`TSTL_NEV-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Threshold selection.
  // ----------------------------------------------------------------------
  // The slow table has no printed value for code 01, so it uses 128 bytes.
  always @* begin
    thr = `TSTL_THR_128;
    if (spd_mode) begin
      case (thr_code)
        2'b00:   thr = `TSTL_THR_64;
        2'b01:   thr = `TSTL_THR_128;
        2'b10:   thr = `TSTL_THR_192;
        2'b11:   thr = `TSTL_THR_256;
        default: thr = `TSTL_THR_128;
      endcase
    end else begin
      case (thr_code)
        2'b00:   thr = `TSTL_THR_128;
        2'b01:   thr = `TSTL_THR_256;
        2'b10:   thr = `TSTL_THR_512;
        2'b11:   thr = `TSTL_THR_1024;
        default: thr = `TSTL_THR_128;
      endcase
    end
  end

  // A frame shorter than the threshold still starts once it is fully loaded,
  // otherwise it would sit in the FIFO for ever.
  always @* begin
    if (sfwd_mode) begin
      start_ok = loaded_q | dma_frame_loaded;
    end else begin
      start_ok = (fifo_level > thr) | loaded_q | dma_frame_loaded;
    end
  end

  // One packet mode stops the DMA once the current frame is complete.
  assign dma_load_allow = ((state_q == ST_MOVE) | (state_q == ST_SEND)) &
                          (~opmode_q[`TSTL_BIT_ONEPKT] | ~loaded_q);

  // ----------------------------------------------------------------------
  // Transmit process state machine.
  // ----------------------------------------------------------------------
  always @* begin
    state_d  = state_q;
    loaded_d = loaded_q | dma_frame_loaded;
    fetch_d  = 1'b0;
    start_d  = 1'b0;
    retry_d  = 1'b0;
    ev_set   = {`TSTL_NEV{1'b0}};
    case (state_q)
      ST_STOP: begin
        loaded_d = 1'b0;
        if (run_cmd) begin
          state_d = ST_FETCH;
          fetch_d = 1'b1;
        end
      end
      ST_FETCH: begin
        if (desc_fetch_ack) begin
          if (desc_dev_owned) begin
            state_d = ST_MOVE;
          end else begin
            state_d = ST_SUSP;
            ev_set[`TSTL_EV_BUFUNAV] = 1'b1;
          end
        end
      end
      ST_SUSP: begin
        if (!run_cmd) begin
          state_d = ST_STOP;
          ev_set[`TSTL_EV_STOPPED] = 1'b1;
        end else if (poll_cmd || auto_poll_expire) begin
          state_d = ST_FETCH;
          fetch_d = 1'b1;
        end
      end
      ST_MOVE: begin
        if (start_ok) begin
          state_d = ST_SEND;
          start_d = 1'b1;
        end
      end
      ST_SEND: begin
        if (mac_underrun) begin
          ev_set[`TSTL_EV_UNDERRUN] = 1'b1;
          if (opmode_q[`TSTL_BIT_RETRY]) begin
            state_d = ST_MOVE;
            retry_d = 1'b1;
          end else begin
            state_d  = ST_SUSP;
            loaded_d = 1'b0;
          end
        end else if (mac_tx_done) begin
          ev_set[`TSTL_EV_DONE] = 1'b1;
          loaded_d = 1'b0;
          if (run_cmd) begin
            state_d = ST_FETCH;
            fetch_d = 1'b1;
          end else begin
            state_d = ST_STOP;
            ev_set[`TSTL_EV_STOPPED] = 1'b1;
          end
        end
      end
      default: begin
        state_d  = ST_STOP;
        loaded_d = 1'b0;
      end
    endcase
  end

  // State and one-cycle command pulses.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q        <= ST_STOP;
      loaded_q       <= 1'b0;
      desc_fetch_req <= 1'b0;
      mac_tx_start   <= 1'b0;
      mac_tx_retry   <= 1'b0;
    end else if (clk_en) begin
      state_q        <= state_d;
      loaded_q       <= loaded_d;
      desc_fetch_req <= fetch_d;
      mac_tx_start   <= start_d;
      mac_tx_retry   <= retry_d;
    end
  end

  // ----------------------------------------------------------------------
  // Link mode outputs.
  // ----------------------------------------------------------------------
  // Registered so the MAC and PHY see clean levels after a mode write.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      loopback_select     <= `TSTL_LB_NORMAL;
      loopback_route      <= 1'b0;
      collision_detect_en <= 1'b1;
      force_collision     <= 1'b0;
      ext_mii_select      <= 1'b1;
      int_phy_enable      <= 1'b0;
    end else if (clk_en) begin
      loopback_select     <= lb_code;
      loopback_route      <= (lb_code != `TSTL_LB_NORMAL);
      collision_detect_en <= (lb_code == `TSTL_LB_NORMAL);
      force_collision     <= opmode_q[`TSTL_BIT_FCOL] & (lb_code == `TSTL_LB_INTERNAL);
      ext_mii_select      <= opmode_q[`TSTL_BIT_EXTMII];
      int_phy_enable      <= ~opmode_q[`TSTL_BIT_EXTMII];
    end
  end

  // ----------------------------------------------------------------------
  // Status flags and interrupt.
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `TSTL_NEV; gi = gi + 1) begin : g_stat
      tstl_sticky u_flag (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .set_ev  (ev_set[gi]),
        .clr_w1c (wr_status & reg_wdata[gi]),
        .mask_en (mask_q[gi]),
        .flag_q  (stat_q[gi]),
        .pend    (pend[gi])
      );
    end
  endgenerate

  // Level interrupt while any unmasked flag is set.
  assign irq = |pend;

  // ----------------------------------------------------------------------
  // Read data, valid the cycle after the read strobe.
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `TSTL_OFS_OPMODE: reg_rdata <= opmode_q;
          `TSTL_OFS_STATUS: reg_rdata <= {28'h000_0000, stat_q};
          `TSTL_OFS_MASK:   reg_rdata <= {28'h000_0000, mask_q};
          `TSTL_OFS_STATE:  reg_rdata <= {28'h000_0000, loaded_q, state_q};
          default:          reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // tstl_ctrl

// >>> dv/tstl_ctrl_checker.sv
/*
  Assertion checker for the transmit start, threshold and loopback control.
  Assumes it sees only the ports of tstl_ctrl and that clk_en gates all state.
*/
`timescale 1ns/1ps
`include "tstl_defs.vh"

module tstl_ctrl_checker (
  input logic        clk_sys, reset, clk_en, reg_wr, reg_rd, irq, desc_fetch_req, desc_fetch_ack,
  input logic        desc_dev_owned, dma_load_allow, dma_frame_loaded, mac_tx_start, mac_tx_retry,
  input logic        mac_tx_done, mac_underrun, auto_poll_expire, loopback_route, collision_detect_en,
  input logic        force_collision, ext_mii_select, int_phy_enable,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata, reg_rdata,
  input logic [11:0] fifo_level,
  input logic [1:0]  loopback_select
);
  logic [31:0] mode_q;
  logic        loaded_q;
  logic        susp_q;
  logic [11:0] thr;

  // Shadows of the mode register, the loaded frame and a host-owned suspend.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_q   <= `TSTL_OPMODE_RST;
      loaded_q <= 1'b0;
      susp_q   <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `TSTL_OFS_OPMODE)
        mode_q <= (reg_wdata & `TSTL_OPMODE_WMASK) | 32'h0200_0000;
      if (dma_frame_loaded)
        loaded_q <= 1'b1;
      else if (desc_fetch_req)
        loaded_q <= 1'b0;
      if (desc_fetch_ack && !desc_dev_owned)
        susp_q <= 1'b1;
      else if (auto_poll_expire || !mode_q[13] || (reg_wr && reg_addr == `TSTL_OFS_POLL))
        susp_q <= 1'b0;
    end
  end

  // Threshold picked by the speed mode bit and the two threshold bits.
  always_comb begin
    case ({mode_q[22], mode_q[15:14]})
      3'd0: thr = `TSTL_THR_128;
      3'd1: thr = `TSTL_THR_256;
      3'd2: thr = `TSTL_THR_512;
      3'd3: thr = `TSTL_THR_1024;
      3'd4: thr = `TSTL_THR_64;
      3'd5: thr = `TSTL_THR_128;
      3'd6: thr = `TSTL_THR_192;
      default: thr = `TSTL_THR_256;
    endcase
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_link_follow: assert property (
    loopback_select == $past(mode_q[11:10]) && ext_mii_select == $past(mode_q[18]))
    else $error("link outputs do not follow the mode register");
  a_phy_inverse: assert property (int_phy_enable != ext_mii_select)
    else $error("internal phy enable equals mii select");
  a_loop_route: assert property (
    loopback_route == (loopback_select != 2'b00) && collision_detect_en == (loopback_select == 2'b00))
    else $error("loopback routing or collision detect wrong");
  a_force_coll: assert property (
    force_collision == ($past(mode_q[12]) && $past(mode_q[11:10]) == 2'b01))
    else $error("force collision outside internal loopback");
  a_start_thresh: assert property (
    mac_tx_start && !$past(mode_q[21]) |->
      $past(fifo_level) > $past(thr) || $past(loaded_q) || $past(dma_frame_loaded))
    else $error("start before the threshold was exceeded");
  a_store_fwd: assert property (
    mac_tx_start && $past(mode_q[21]) |-> $past(loaded_q) || $past(dma_frame_loaded))
    else $error("store and forward start before frame loaded");
  a_retry_cause: assert property (mac_tx_retry |-> $past(mac_underrun) && $past(mode_q[17]))
    else $error("retry without underrun in retry mode");
  a_retry_restart: assert property (mac_tx_retry |-> ##[1:40] mac_tx_start)
    else $error("retried frame not started again");
  a_one_packet: assert property (mode_q[16] && loaded_q |-> !dma_load_allow)
    else $error("fifo loading beyond one packet");
  a_fetch_run: assert property (desc_fetch_req |-> $past(mode_q[13]))
    else $error("descriptor fetch while stopped");
  a_susp_hold: assert property (desc_fetch_req |-> !susp_q)
    else $error("fetch while suspended without poll");
endmodule // tstl_ctrl_checker

bind tstl_ctrl tstl_ctrl_checker tstl_ctrl_checker_i (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .irq(irq),
  .desc_fetch_req(desc_fetch_req), .desc_fetch_ack(desc_fetch_ack), .desc_dev_owned(desc_dev_owned),
  .dma_load_allow(dma_load_allow), .dma_frame_loaded(dma_frame_loaded), .mac_tx_start(mac_tx_start),
  .mac_tx_retry(mac_tx_retry), .mac_tx_done(mac_tx_done), .mac_underrun(mac_underrun),
  .auto_poll_expire(auto_poll_expire), .loopback_route(loopback_route),
  .collision_detect_en(collision_detect_en), .force_collision(force_collision),
  .ext_mii_select(ext_mii_select), .int_phy_enable(int_phy_enable), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_level(fifo_level), .loopback_select(loopback_select));

// >>> dv/tstl_far_model.sv
/*
  Model of the descriptor engine, DMA and MAC beside the control block.
  Assumes one clock; own and urun come from the bench and are sampled on edges.
*/
`timescale 1ns/1ps

module tstl_far_model #(
  parameter int FLEN = 1600
) (
  input  logic        clk_sys, reset, desc_fetch_req, dma_load_allow, mac_tx_start, own, urun,
  output logic        desc_fetch_ack, desc_dev_owned, dma_frame_loaded, mac_tx_done, mac_underrun,
  output logic [11:0] fifo_level
);
  logic       req_q;
  logic [2:0] cnt_q;

  // Ack two cycles after a request; ownership is junk outside the ack so stale values cannot pass.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {req_q, desc_fetch_ack, desc_dev_owned, dma_frame_loaded, mac_tx_done, mac_underrun} <= '0;
      fifo_level <= '0;
      cnt_q      <= '0;
    end else begin
      req_q            <= desc_fetch_req;
      desc_fetch_ack   <= req_q;
      desc_dev_owned   <= req_q ? own : !desc_dev_owned;
      dma_frame_loaded <= dma_load_allow && fifo_level + 12'd64 == 12'(FLEN);
      if (dma_load_allow && fifo_level < 12'(FLEN))
        fifo_level <= fifo_level + 12'd64;
      mac_tx_done  <= cnt_q == 3'd1 && !urun;
      mac_underrun <= cnt_q == 3'd1 && urun;
      if (mac_tx_start)
        cnt_q <= 3'd6;
      else if (cnt_q != 3'd0)
        cnt_q <= cnt_q - 3'd1;
      if (cnt_q == 3'd1 && !urun)
        fifo_level <= '0;
    end
  end
endmodule // tstl_far_model

// >>> dv/tstl_ctrl_tb.sv
/*
  Self-checking bench for tstl_ctrl with the far side model.
  Assumes the checker is bound to the design; clk_en is held high.
*/
`timescale 1ns/1ps

module tstl_ctrl_tb;
  logic        clk_sys = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, auto_poll_expire = 0;
  logic        own = 1, urun = 0, irq, desc_fetch_req, desc_fetch_ack, desc_dev_owned;
  logic        dma_load_allow, dma_frame_loaded, mac_tx_start, mac_tx_retry, mac_tx_done, mac_underrun;
  logic        loopback_route, collision_detect_en, force_collision, ext_mii_select, int_phy_enable;
  logic [1:0]  loopback_select;
  logic [2:0]  ev;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d, m;
  logic [11:0] fifo_level, lvl_q, seen;
  int          num_errors = 0, checked = 0, thr_tab[8] = '{128, 256, 512, 1024, 64, 128, 192, 256};

  always #2.5 clk_sys = ~clk_sys;
  assign ev = {mac_tx_done, mac_tx_retry, mac_tx_start};

  // Level in the cycle before each start, which is the cycle the start was decided in.
  always @(posedge clk_sys) begin
    lvl_q <= fifo_level;
    if (mac_tx_start) seen <= lvl_q;
  end

  tstl_ctrl tstl_ctrl_i (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .desc_fetch_req(desc_fetch_req), .desc_fetch_ack(desc_fetch_ack), .desc_dev_owned(desc_dev_owned),
    .dma_load_allow(dma_load_allow), .dma_frame_loaded(dma_frame_loaded), .fifo_level(fifo_level),
    .mac_tx_start(mac_tx_start), .mac_tx_retry(mac_tx_retry), .mac_tx_done(mac_tx_done),
    .mac_underrun(mac_underrun), .auto_poll_expire(auto_poll_expire), .loopback_select(loopback_select),
    .loopback_route(loopback_route), .collision_detect_en(collision_detect_en),
    .force_collision(force_collision), .ext_mii_select(ext_mii_select), .int_phy_enable(int_phy_enable));
  tstl_far_model tstl_far_model_i (.clk_sys(clk_sys), .reset(reset), .desc_fetch_req(desc_fetch_req),
    .dma_load_allow(dma_load_allow), .mac_tx_start(mac_tx_start), .own(own), .urun(urun),
    .desc_fetch_ack(desc_fetch_ack), .desc_dev_owned(desc_dev_owned), .dma_frame_loaded(dma_frame_loaded),
    .mac_tx_done(mac_tx_done), .mac_underrun(mac_underrun), .fifo_level(fifo_level));

  // ----------------------------------------------------------------------
  // Bus tasks and checks.
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen_v, exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait on one event pulse, so a stuck process cannot hang the run.
  task automatic wev(input int k);
    int n = 0;
    do @(negedge clk_sys); while (!ev[k] && ++n < 400);
    if (n >= 400) chk("event_wait", 32'(k), 32'hffff_ffff);
  endtask
  // Stop the process, wait for the frame end, check and clear the status.
  task automatic fin(input logic [31:0] mv, exp_v);
    wr(8'h00, mv);
    wev(2);
    repeat (3) @(posedge clk_sys);
    rd(8'h04);
    chk("status", d, exp_v);
    wr(8'h04, 32'h0000_000f);
  endtask
  task automatic summarize;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h00);
    chk("mode_reset", d, 32'h0244_0000);
    chk("mii_pins", {ext_mii_select, int_phy_enable}, 32'h2);
    rd(8'h14);
    chk("unmapped", d, 32'h0);
    for (int lb = 0; lb < 4; lb++) begin
      wr(8'h00, 32'h0000_1000 | (lb << 10));
      repeat (2) @(posedge clk_sys);
      #1 d = {loopback_select, loopback_route, collision_detect_en, force_collision, int_phy_enable};
      chk("link", d, {lb[1:0], lb != 0, lb == 0, lb == 1, 1'b1});
    end
    for (int i = 0; i < 8; i++) begin
      m = 32'h0004_0000 | (i[2] << 22) | (i[1:0] << 14);
      wr(8'h00, m | 32'h0000_2000);
      wev(0);
      @(posedge clk_sys);
      #1 chk("start_level", seen, (thr_tab[i] / 64 + 1) * 64);
      fin(m, 32'h3);
    end
    // Store and forward in one packet mode: the start waits for the whole frame.
    wr(8'h00, 32'h0025_2000);
    wev(0);
    @(posedge clk_sys);
    #1 chk("store_fwd_level", seen, 32'd1600);
    fin(32'h0004_0000, 32'h3);
    // Underrun with retry: the frame is sent again, underrun raises the interrupt.
    wr(8'h08, 32'h8);
    urun <= 1'b1;
    wr(8'h00, 32'h0006_2000);
    wev(1);
    @(posedge clk_sys);
    urun <= 1'b0;
    wev(0);
    chk("irq_on", irq, 32'h1);
    fin(32'h0004_0000, 32'hb);
    urun <= 1'b1;
    #1 chk("irq_clear", irq, 32'h0);
    // Underrun without retry suspends the process.
    wr(8'h00, 32'h0004_2000);
    wev(0);
    repeat (10) @(posedge clk_sys);
    urun <= 1'b0;
    rd(8'h10);
    chk("suspend", d[2:0], 32'h2);
    // Host-owned descriptor after a poll: suspend, buffer unavailable, interrupt.
    own <= 1'b0;
    wr(8'h04, 32'hf);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h0);
    repeat (6) @(posedge clk_sys);
    rd(8'h04);
    chk("buf_unavail", d, 32'h4);
    chk("irq_unav", irq, 32'h1);
    wr(8'h08, 32'h0);
    #1 chk("irq_masked", irq, 32'h0);
    repeat (20) @(posedge clk_sys);
    rd(8'h10);
    chk("still_susp", d[2:0], 32'h2);
    @(posedge clk_sys);
    own <= 1'b1;
    auto_poll_expire <= 1'b1;
    @(posedge clk_sys);
    auto_poll_expire <= 1'b0;
    wev(0);
    fin(32'h0004_0000, 32'h7);
    summarize();
  end

  // Watchdog: the tests need well under a thousand cycles; this allows twenty thousand.
  initial begin
    #100000;
    chk("watchdog", 32'h1, 32'h0);
    summarize();
  end
endmodule // tstl_ctrl_tb
